// ---- pag_gate.sv ----
`default_nettype none
module pag_gate
    import pag_pkg::*;
(
    input  wire logic        i_mclk,
    input  wire logic        i_rst,
    input  wire logic        i_req_valid,
    input  wire logic        i_req_write,
    input  wire logic        i_req_aux,
    input  wire logic [7:0]  i_req_table,
    input  wire logic [7:0]  i_req_addr,
    input  wire logic [7:0]  i_req_wdata,
    input  wire logic        i_pw1,
    input  wire logic        i_pw2,
    input  wire logic        i_mask,
    output logic             o_req_allow,
    output logic             o_wr_commit,
    output logic             o_rd_valid,
    output logic [7:0]       o_rd_data,
    output logic             o_rd_own,
    output logic [7:0]       o_access_grant_rw,
    output logic [7:0]       o_access_grant_read_aux
);
    function automatic pag_region_t decode(input logic aux, input logic [7:0] tbl,
                                           input logic [7:0] addr, input logic mask);
        pag_region_t r;
        r = RG_FREE;
        if (aux)
        begin
            if (addr < ADDR_UPPER_BASE)
            begin
                r = RG_AUX_LOW;
            end
            else
            begin
                r = RG_AUX_HIGH;
            end
        end
        else if (addr < ADDR_UPPER_BASE)
        begin
            if (addr <= ADDR_MAIN_LOW_LAST)
            begin
                r = RG_MAIN_LOW;
            end
        end
        else if (addr >= ADDR_TAIL_BASE && (tbl == TBL_THRESHOLDS || tbl == TBL_MASKED_ALT))
        begin
            if (tbl == (mask ? TBL_MASKED_ALT : TBL_THRESHOLDS))
            begin
                r = RG_TAIL;
            end
            else
            begin
                r = RG_LOCKED;
            end
        end
        else if (tbl == TBL_THRESHOLDS)
        begin
            if (addr <= ADDR_THR_LOW_LAST)
            begin
                r = RG_THR_LOW;
            end
            else if (addr <= ADDR_THR_HIGH_LAST)
            begin
                r = RG_THR_HIGH;
            end
            else
            begin
                r = RG_LOCKED;
            end
        end
        else if (tbl == TBL_CONFIG)
        begin
            if (addr >= ADDR_KEY1_BASE && addr <= ADDR_KEY1_LAST)
            begin
                r = RG_KEY1;
            end
            else
            begin
                r = RG_CONFIG;
            end
        end
        else if (tbl == TBL_LOOKUP)
        begin
            r = RG_LOOKUP;
        end
        return r;
    endfunction

    function automatic logic own_reg(input logic aux, input logic [7:0] tbl,
                                     input logic [7:0] addr, input logic [7:0] ofs);
        return !aux && tbl == TBL_CONFIG && addr == ofs;
    endfunction

    pag_region_t region;
    logic        allow;
    logic        hit_rw;
    logic        hit_rd;
    logic [7:0]  grant_rw_q;
    logic [7:0]  grant_rw_d;
    logic [7:0]  grant_rd_q;
    logic [7:0]  grant_rd_d;
    logic        commit_q;
    logic        commit_d;
    logic        rd_valid_q;
    logic        rd_valid_d;
    logic [7:0]  rd_data_q;
    logic [7:0]  rd_data_d;
    logic        rd_own_q;
    logic        rd_own_d;

    assign region = decode(i_req_aux, i_req_table, i_req_addr, i_mask);
    assign hit_rw = own_reg(i_req_aux, i_req_table, i_req_addr, ACCESS_GRANT_RW_OFS);
    assign hit_rd = own_reg(i_req_aux, i_req_table, i_req_addr, ACCESS_GRANT_READ_AUX_OFS);

    pag_check u_check (
        .i_region   (region),
        .i_write    (i_req_write),
        .i_pw1      (i_pw1),
        .i_pw2      (i_pw2),
        .i_grant_rw ({1'b0, grant_rw_q[6:0]}),
        .i_grant_rd (grant_rd_q),
        .o_allow    (allow)
    );

    assign o_req_allow = i_req_valid && allow;

    always_comb
    begin
        grant_rw_d = grant_rw_q;
        grant_rd_d = grant_rd_q;
        if (i_req_valid && i_req_write && allow)
        begin
            if (hit_rw)
            begin
                grant_rw_d = i_req_wdata;
                if (!i_pw2)
                begin
                    grant_rw_d[GRANT_RW_CONFIG_TABLE] = grant_rw_q[GRANT_RW_CONFIG_TABLE];
                end
            end
            if (hit_rd)
            begin
                grant_rd_d = i_req_wdata;
            end
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            grant_rw_q <= ACCESS_GRANT_RW_RST;
            grant_rd_q <= ACCESS_GRANT_READ_AUX_RST;
        end
        else
        begin
            grant_rw_q <= grant_rw_d;
            grant_rd_q <= grant_rd_d;
        end
    end

    always_comb
    begin
        commit_d   = 1'b0;
        rd_valid_d = 1'b0;
        rd_data_d  = 8'h00;
        rd_own_d   = 1'b0;
        if (i_req_valid && i_req_write)
        begin
            commit_d = allow;
        end
        else if (i_req_valid)
        begin
            rd_valid_d = 1'b1;
            rd_own_d   = hit_rw || hit_rd;
            if (allow && hit_rw)
            begin
                rd_data_d = grant_rw_q;
            end
            else if (allow && hit_rd)
            begin
                rd_data_d = grant_rd_q;
            end
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            commit_q   <= 1'b0;
            rd_valid_q <= 1'b0;
            rd_data_q  <= 8'h00;
            rd_own_q   <= 1'b0;
        end
        else
        begin
            commit_q   <= commit_d;
            rd_valid_q <= rd_valid_d;
            rd_data_q  <= rd_data_d;
            rd_own_q   <= rd_own_d;
        end
    end

    assign o_wr_commit             = commit_q;
    assign o_rd_valid              = rd_valid_q;
    assign o_rd_data               = rd_data_q;
    assign o_rd_own                = rd_own_q;
    assign o_access_grant_rw       = grant_rw_q;
    assign o_access_grant_read_aux = grant_rd_q;
endmodule
`default_nettype wire

// ---- pag_pkg.sv ----
`default_nettype none
package pag_pkg;
    // enable registers inside the configuration table
    localparam logic [7:0] ACCESS_GRANT_RW_OFS       = 8'hC0;
    localparam logic [7:0] ACCESS_GRANT_READ_AUX_OFS = 8'hC1;
    localparam logic [7:0] ACCESS_GRANT_RW_RST       = 8'h10;
    localparam logic [7:0] ACCESS_GRANT_READ_AUX_RST = 8'h03;

    // access_grant_rw fields
    localparam int GRANT_RW_MASKED_TAIL      = 6;
    localparam int GRANT_RW_CONFIG_TABLE     = 5;
    localparam int GRANT_RW_THRESHOLDS_LOW   = 4;
    localparam int GRANT_RW_THRESHOLDS_HIGH  = 3;
    localparam int GRANT_WRITE_MAIN_LOW      = 2;
    localparam int GRANT_WRITE_AUX_LOW       = 1;
    localparam int GRANT_WRITE_AUX_HIGH      = 0;

    // access_grant_read_aux fields
    localparam int GRANT_RW_LOOKUP_PAGE        = 7;
    localparam int GRANT_READ_MASKED_TAIL      = 6;
    localparam int GRANT_READ_CONFIG_TABLE     = 5;
    localparam int GRANT_READ_THRESHOLDS_LOW   = 4;
    localparam int GRANT_READ_THRESHOLDS_HIGH  = 3;
    localparam int GRANT_WRITE_LEVEL1_KEY      = 2;
    localparam int OPEN_WRITE_AUX_LOW          = 1;
    localparam int OPEN_WRITE_AUX_HIGH         = 0;

    // table numbers of the upper page
    localparam logic [7:0] TBL_THRESHOLDS   = 8'h01;
    localparam logic [7:0] TBL_CONFIG       = 8'h02;
    localparam logic [7:0] TBL_LOOKUP       = 8'h04;
    localparam logic [7:0] TBL_MASKED_ALT   = 8'h05;

    // address bounds
    localparam logic [7:0] ADDR_UPPER_BASE      = 8'h80;
    localparam logic [7:0] ADDR_MAIN_LOW_LAST   = 8'h5F;
    localparam logic [7:0] ADDR_THR_LOW_LAST    = 8'hBF;
    localparam logic [7:0] ADDR_THR_HIGH_LAST   = 8'hF7;
    localparam logic [7:0] ADDR_TAIL_BASE       = 8'hF8;
    localparam logic [7:0] ADDR_KEY1_BASE       = 8'hB0;
    localparam logic [7:0] ADDR_KEY1_LAST       = 8'hB3;

    typedef enum logic [3:0] {
        RG_FREE       = 4'h0,
        RG_MAIN_LOW   = 4'h1,
        RG_THR_LOW    = 4'h2,
        RG_THR_HIGH   = 4'h3,
        RG_TAIL       = 4'h4,
        RG_CONFIG     = 4'h5,
        RG_KEY1       = 4'h6,
        RG_LOOKUP     = 4'h7,
        RG_AUX_LOW    = 4'h8,
        RG_AUX_HIGH   = 4'h9,
        RG_LOCKED     = 4'hA
    } pag_region_t;
endpackage
`default_nettype wire

// ---- pag_check.sv ----
`default_nettype none
module pag_check
    import pag_pkg::*;
(
    input  wire pag_region_t i_region,
    input  wire logic        i_write,
    input  wire logic        i_pw1,
    input  wire logic        i_pw2,
    input  wire logic [7:0]  i_grant_rw,
    input  wire logic [7:0]  i_grant_rd,
    output logic             o_allow
);
    logic lvl1_rw;
    logic lvl1_rd;
    logic lvl0_wr;

    always_comb
    begin
        lvl1_rw = 1'b0;
        lvl1_rd = 1'b0;
        lvl0_wr = 1'b0;
        case (i_region)
            RG_TAIL:
            begin
                lvl1_rw = i_grant_rw[GRANT_RW_MASKED_TAIL];
                lvl1_rd = i_grant_rd[GRANT_READ_MASKED_TAIL];
            end
            RG_CONFIG, RG_KEY1:
            begin
                lvl1_rw = i_grant_rw[GRANT_RW_CONFIG_TABLE];
                lvl1_rd = i_grant_rd[GRANT_READ_CONFIG_TABLE];
            end
            RG_THR_LOW:
            begin
                lvl1_rw = i_grant_rw[GRANT_RW_THRESHOLDS_LOW];
                lvl1_rd = i_grant_rd[GRANT_READ_THRESHOLDS_LOW];
            end
            RG_THR_HIGH:
            begin
                lvl1_rw = i_grant_rw[GRANT_RW_THRESHOLDS_HIGH];
                lvl1_rd = i_grant_rd[GRANT_READ_THRESHOLDS_HIGH];
            end
            RG_LOOKUP:
            begin
                lvl1_rw = i_grant_rd[GRANT_RW_LOOKUP_PAGE];
            end
            RG_MAIN_LOW:
            begin
                lvl1_rw = i_grant_rw[GRANT_WRITE_MAIN_LOW];
                lvl0_wr = 1'b0;
            end
            RG_AUX_LOW:
            begin
                lvl1_rw = i_grant_rw[GRANT_WRITE_AUX_LOW];
                lvl0_wr = i_grant_rd[OPEN_WRITE_AUX_LOW];
            end
            RG_AUX_HIGH:
            begin
                lvl1_rw = i_grant_rw[GRANT_WRITE_AUX_HIGH];
                lvl0_wr = i_grant_rd[OPEN_WRITE_AUX_HIGH];
            end
            default:
            begin
                lvl1_rw = 1'b0;
            end
        endcase
    end

    always_comb
    begin
        o_allow = 1'b0;
        if (i_pw2 || i_region == RG_FREE)
        begin
            o_allow = i_region != RG_LOCKED || i_pw2;
        end
        else if (i_write)
        begin
            if (i_region == RG_KEY1)
            begin
                o_allow = i_pw1 && i_grant_rd[GRANT_WRITE_LEVEL1_KEY];
            end
            else
            begin
                o_allow = (i_pw1 && lvl1_rw) || lvl0_wr;
            end
        end
        else
        begin
            case (i_region)
                RG_MAIN_LOW, RG_AUX_LOW, RG_AUX_HIGH: o_allow = 1'b1;
                default: o_allow = i_pw1 && (lvl1_rw || lvl1_rd);
            endcase
        end
    end
endmodule
`default_nettype wire

// ---- pag_gate_monitor.sv ----
`default_nettype none
module pag_gate_monitor
    import pag_pkg::*;
(
    input  wire logic       i_mclk,
    input  wire logic       i_rst,
    input  wire logic       i_req_valid,
    input  wire logic       i_req_write,
    input  wire logic       i_req_aux,
    input  wire logic [7:0] i_req_table,
    input  wire logic [7:0] i_req_addr,
    input  wire logic [7:0] i_req_wdata,
    input  wire logic       i_pw1,
    input  wire logic       i_pw2,
    input  wire logic       o_req_allow,
    input  wire logic       o_wr_commit,
    input  wire logic       o_rd_valid,
    input  wire logic [7:0] o_rd_data,
    input  wire logic [7:0] o_access_grant_rw,
    input  wire logic [7:0] o_access_grant_read_aux
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    logic wr;
    logic rd;
    logic g2;
    assign wr = i_req_valid && i_req_write;
    assign rd = i_req_valid && !i_req_write;
    assign g2 = !i_req_aux && i_req_table == 8'h02;
    a_commit_on_allow: assert property (wr && o_req_allow |=> o_wr_commit)
        else $error("allowed write not committed");
    a_no_refused_commit: assert property (wr && !o_req_allow |=> !o_wr_commit)
        else $error("refused write committed");
    a_read_answer: assert property (rd |=> o_rd_valid)
        else $error("read not answered");
    a_refused_read_zero: assert property (rd && !o_req_allow |=> o_rd_data == 8'h00)
        else $error("refused read returned data");
    a_level2_full: assert property (i_req_valid && i_pw2 |-> o_req_allow)
        else $error("level 2 refused");
    a_level2_value: assert property (wr && i_pw2 && g2 && i_req_addr == 8'hC0
        |=> o_access_grant_rw == $past(i_req_wdata)) else $error("grant register not written");
    a_key_bit_hold: assert property (wr && !i_pw2 && g2 && i_req_addr == 8'hC0
        |=> o_access_grant_rw[5] == $past(o_access_grant_rw[5])) else $error("bit 5 changed");
    a_aux_read_free: assert property (rd && i_req_aux |-> o_req_allow)
        else $error("aux read refused");
    a_main_low_read: assert property (rd && !i_req_aux && i_req_addr <= 8'h5F |-> o_req_allow)
        else $error("main low read refused");
    a_open_aux_write: assert property (wr && i_req_aux && !i_pw1 && !i_pw2
        |-> o_req_allow == o_access_grant_read_aux[i_req_addr[7] ? 0 : 1])
        else $error("open aux write wrong");
    a_lookup_gate: assert property (i_req_valid && i_pw1 && !i_pw2 && g2 == 1'b0
        && !i_req_aux && i_req_table == 8'h04 && i_req_addr[7]
        |-> o_req_allow == o_access_grant_read_aux[7]) else $error("lookup gate wrong");
    a_grants_stable: assert property (!(wr && o_req_allow && g2 && i_req_addr[7:1] == 7'h60)
        |=> $stable({o_access_grant_rw, o_access_grant_read_aux})) else $error("grant moved");
    cover property (wr && o_req_allow && g2);
    cover property (rd && !o_req_allow);
    cover property (wr && i_req_aux && !i_pw1 && !i_pw2);
endmodule
bind pag_gate pag_gate_monitor u_mon (.i_mclk(i_mclk), .i_rst(i_rst), .i_req_valid(i_req_valid),
    .i_req_write(i_req_write), .i_req_aux(i_req_aux), .i_req_table(i_req_table),
    .i_req_addr(i_req_addr), .i_req_wdata(i_req_wdata), .i_pw1(i_pw1), .i_pw2(i_pw2),
    .o_req_allow(o_req_allow), .o_wr_commit(o_wr_commit), .o_rd_valid(o_rd_valid),
    .o_rd_data(o_rd_data), .o_access_grant_rw(o_access_grant_rw),
    .o_access_grant_read_aux(o_access_grant_read_aux));
`default_nettype wire

// ---- pag_host.sv ----
`default_nettype none
module pag_host
(
    input  wire logic      i_mclk,
    input  wire logic      i_allow,
    output var logic       o_valid,
    output var logic [28:0] o_req
);
    timeunit 1ns;
    timeprecision 1ns;
    initial {o_valid, o_req} = '0;
    // one access per call, allow sampled mid-cycle
    task automatic acc(input logic [28:0] r, output logic a);
        @(posedge i_mclk);
        o_valid <= 1'b1;
        o_req <= r;
        @(negedge i_mclk);
        a = i_allow;
    endtask
    // idle: data lines wander
    task automatic idle();
        @(posedge i_mclk);
        o_valid <= 1'b0;
        o_req <= ~o_req;
    endtask
endmodule
`default_nettype wire

// ---- tb.sv ----
`default_nettype none
module tb import pag_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic        i_mclk, i_rst, vl, alw, wc, rv, ro;
    logic [28:0] rq;
    logic [7:0]  rd, grw, grd, erw, erd;
    logic [31:0] r;
    logic [7:0]  tl[5] = '{8'h01, 8'h02, 8'h04, 8'h05, 8'h03};
    logic [16:0] q[$];
    int          fails, checked;
    pag_host u_host (.i_mclk(i_mclk), .i_allow(alw), .o_valid(vl), .o_req(rq));
    pag_gate uut (.i_mclk(i_mclk), .i_rst(i_rst), .i_req_valid(vl), .i_req_write(rq[28]),
        .i_req_aux(rq[27]), .i_req_table(rq[26:19]), .i_req_addr(rq[18:11]),
        .i_req_wdata(rq[10:3]), .i_pw1(rq[2]), .i_pw2(rq[1]), .i_mask(rq[0]),
        .o_req_allow(alw), .o_wr_commit(wc), .o_rd_valid(rv), .o_rd_data(rd), .o_rd_own(ro),
        .o_access_grant_rw(grw), .o_access_grant_read_aux(grd));
    initial
    begin
        i_mclk = 1'b0;
        forever #10 i_mclk = ~i_mclk;
    end
    task automatic chk(string n, logic [16:0] s, logic [16:0] e);
        checked++;
        if (s !== e)
        begin
            fails++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    function automatic logic ok(logic w, a, logic [7:0] t, d, logic q1, q2, k);
        int b;
        b = d < 8'hC0 ? 4 : 3;
        if (q2) return 1'b1;
        if (a) return !w || (q1 && erw[d[7] ? 0 : 1]) || erd[d[7] ? 0 : 1];
        if (!d[7]) return !w || d > 8'h5F || (q1 && erw[2]);
        if (t == 8'h01 || t == 8'h05)
        begin
            if (d >= 8'hF8) return t == (k ? 8'h05 : 8'h01) && q1 && (erw[6] || !w && erd[6]);
            if (t == 8'h05) return 1'b1;
            return q1 && (erw[b] || !w && erd[b]);
        end
        if (t == 8'h02 && w && d inside {[8'hB0:8'hB3]}) return q1 && erd[2];
        if (t == 8'h02) return q1 && (erw[5] || !w && erd[5]);
        if (t == 8'h04) return q1 && erd[7];
        return 1'b1;
    endfunction
    task automatic go(logic w, a, logic [7:0] t, d, v, logic q1, q2, k);
        logic al, e, own;
        e = ok(w, a, t, d, q1, q2, k);
        own = !a && t == 8'h02 && d[7:1] == 7'h60;
        u_host.acc({w, a, t, d, v, q1, q2, k}, al);
        chk("allow", {16'h0, al}, {16'h0, e});
        if (!w) q.push_back({8'h0, own, e && own ? (d[0] ? erd : erw) : 8'h00});
        else if (e)
        begin
            if (own && !d[0]) erw = q2 ? v : {v[7:6], erw[5], v[4:0]};
            if (own && d[0]) erd = v;
            q.push_back({1'b1, erw, erd});
        end
    endtask
    always @(negedge i_mclk)
    begin
        if (!i_rst && (rv || wc))
        begin
            if (q.size() == 0) chk("unexpected", 17'h1, 17'h0);
            else chk("result", rv ? {8'h0, ro, rd} : {1'b1, grw, grd}, q.pop_front());
        end
    end
    task automatic close_out();
        if (q.size() != 0) chk("pending", 17'(q.size()), 17'h0);
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial
    begin
        fails = 0;
        checked = 0;
        i_rst = 1'b1;
        erw = 8'h10;
        erd = 8'h03;
        void'($urandom(69258));
        repeat (5) @(posedge i_mclk);
        i_rst <= 1'b0;
        chk("rst", {1'b0, grw, grd}, {1'b0, 8'h10, 8'h03});
        go(1, 0, 8'h02, 8'hC0, 8'hFF, 1, 0, 0);
        go(0, 0, 8'h02, 8'hC0, 8'h00, 1, 0, 0);
        go(1, 1, 8'h00, 8'h10, 8'h55, 0, 0, 0);
        go(1, 0, 8'h02, 8'hC1, 8'h00, 0, 1, 0);
        go(1, 1, 8'h00, 8'h90, 8'h55, 0, 0, 0);
        go(1, 0, 8'h02, 8'hC0, 8'hFF, 0, 1, 0);
        go(1, 0, 8'h02, 8'hC0, 8'h00, 1, 0, 0);
        go(0, 0, 8'h02, 8'hC0, 8'h00, 1, 0, 0);
        go(1, 0, 8'h02, 8'hB1, 8'h00, 1, 0, 0);
        repeat (600)
        begin
            r = $urandom;
            go(r[0], r[1], tl[r[4:2] % 3'd5], r[5] ? {7'h60, r[6]} : r[15:8], r[23:16],
                r[24], r[27:25] == 3'h0, r[28]);
        end
        u_host.idle();
        repeat (3) @(posedge i_mclk);
        close_out();
    end
endmodule
`default_nettype wire
